// *** core/vdt_pkg.sv ***
// constants, field layouts and state codes shared by the dual-port board slave
// assumes a 20 MHz system clock and byte-wide registers on the low data lines
package vdt_pkg;

  localparam int unsigned CLK_SYS_HZ = 20_000_000;

  // register offsets within one port, odd bytes only; read and write share them
  localparam logic [3:0] OFF_DATA      = 4'h1;
  localparam logic [3:0] OFF_STATUS1   = 4'h3;
  localparam logic [3:0] OFF_STATUS2   = 4'h5;
  localparam logic [3:0] OFF_POLL      = 4'h7;
  localparam logic [3:0] OFF_ADDRESS   = 4'h9;
  localparam logic [3:0] OFF_AUX       = 4'hB;
  localparam logic [3:0] OFF_OWN_ADDR  = 4'hD;
  localparam logic [3:0] OFF_EOS       = 4'hF;
  localparam logic [4:0] PORT_B_OFFSET = 5'h10;

  // short i/o address modifier codes
  localparam logic [5:0] AM_SHORT_SUP  = 6'h2D;
  localparam logic [5:0] AM_SHORT_USER = 6'h29;

  // event vector positions
  localparam int EV_DATA_IN  = 0;
  localparam int EV_DATA_OUT = 1;
  localparam int EV_HS_ERROR = 2;
  localparam int EV_CLEAR    = 3;
  localparam int EV_END_RX   = 4;
  localparam int EV_TRIGGER  = 5;
  localparam int EV_SEC_ADDR = 6;
  localparam int EV_UNK_CMD  = 7;
  localparam int EV_ADDR_CHG = 8;
  localparam int EV_REMOTE   = 9;
  localparam int EV_LOCKOUT  = 10;
  localparam int EV_CMD_OUT  = 11;
  localparam int EV_SRQ      = 12;
  localparam int EV_COUNT    = 13;

  // status two: low nibble from events, service request at 6, chip interrupt at 7
  localparam int ST2_SRQ_BIT = 6;
  localparam int ST2_INT_BIT = 7;
  localparam int OWN_SEL_BIT = 7;

  // values after reset
  localparam logic [7:0] BYTE_RESET  = 8'h00;
  localparam logic [6:0] ADDR_RESET  = 7'h00;
  localparam logic [2:0] INDEX_RESET = 3'h0;

  typedef enum logic [3:0] {
    ST_IDLE    = 4'b0001,
    ST_ACK     = 4'b0010,
    ST_PASS    = 4'b0100,
    ST_RELEASE = 4'b1000
  } vdt_state_t;

  // register index from a printed offset
  function automatic logic [2:0] idx(input logic [3:0] off);
    idx = off[3:1];
  endfunction : idx

endpackage : vdt_pkg

// *** core/vdt_port.sv ***
// one controller port: status, masks, interrupt output and instrument-bus drivers
// assumes strobes, events and bus-logic inputs are synchronous to clk_sys
`timescale 1ns/1ps
module vdt_port (
  input  wire logic       clk_sys,
  input  wire logic       rst_n,
  input  wire logic       chip_reset,
  input  wire logic [2:0] reg_index,
  input  wire logic       wr_stb,
  input  wire logic       rd_stb,
  input  wire logic [7:0] wr_data,
  input  wire logic [12:0] events,
  input  wire logic [7:0] rx_byte,
  input  wire logic [7:0] addr_status,
  input  wire logic [7:0] cmd_pass,
  input  wire logic       ppoll_active,
  input  wire logic       bus_drive,
  input  wire logic [7:0] bus_byte,
  output logic      [7:0] rd_data,
  output logic            chip_int,
  output logic      [7:0] cmd_byte,
  output logic      [2:0] cmd_index,
  output logic            cmd_stb,
  output logic      [7:0] ib_o,
  output logic      [7:0] ib_oe
);
  logic [7:0] status1;
  logic [7:0] status2;
  logic [7:0] mask1;
  logic [7:0] mask2;
  logic [7:0] poll_mode;
  logic [6:0] own_addr0;
  logic [6:0] own_addr1;
  logic [7:0] ev1;
  logic [7:0] ev2;

  assign ev1 = events[7:0];
  assign ev2 = {1'b0, events[vdt_pkg::EV_SRQ], 2'b00, events[11:8]};

  // reading a status register clears it, but an event in the same cycle survives
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      status1 <= vdt_pkg::BYTE_RESET;
      status2 <= vdt_pkg::BYTE_RESET;
    end else if (chip_reset) begin
      status1 <= vdt_pkg::BYTE_RESET;
      status2 <= vdt_pkg::BYTE_RESET;
    end else begin
      status1 <= ((rd_stb && reg_index == vdt_pkg::idx(vdt_pkg::OFF_STATUS1)) ?
                  vdt_pkg::BYTE_RESET : status1) | ev1;
      status2 <= ((rd_stb && reg_index == vdt_pkg::idx(vdt_pkg::OFF_STATUS2)) ?
                  vdt_pkg::BYTE_RESET : status2) | ev2;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      mask1     <= vdt_pkg::BYTE_RESET;
      mask2     <= vdt_pkg::BYTE_RESET;
      poll_mode <= vdt_pkg::BYTE_RESET;
      own_addr0 <= vdt_pkg::ADDR_RESET;
      own_addr1 <= vdt_pkg::ADDR_RESET;
    end else if (chip_reset) begin
      mask1     <= vdt_pkg::BYTE_RESET;
      mask2     <= vdt_pkg::BYTE_RESET;
      poll_mode <= vdt_pkg::BYTE_RESET;
      own_addr0 <= vdt_pkg::ADDR_RESET;
      own_addr1 <= vdt_pkg::ADDR_RESET;
    end else if (wr_stb) begin
      unique case (reg_index)
        vdt_pkg::idx(vdt_pkg::OFF_STATUS1): mask1 <= wr_data;
        vdt_pkg::idx(vdt_pkg::OFF_STATUS2): mask2 <= wr_data;
        vdt_pkg::idx(vdt_pkg::OFF_POLL):    poll_mode <= wr_data;
        vdt_pkg::idx(vdt_pkg::OFF_OWN_ADDR): begin
          if (wr_data[vdt_pkg::OWN_SEL_BIT]) own_addr1 <= wr_data[6:0];
          else                               own_addr0 <= wr_data[6:0];
        end
        default: ;
      endcase
    end
  end

  // every write outside chip reset is also handed to the bus logic, which owns the command registers
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      cmd_byte  <= vdt_pkg::BYTE_RESET;
      cmd_index <= vdt_pkg::INDEX_RESET;
      cmd_stb   <= 1'b0;
    end else begin
      cmd_stb <= wr_stb && !chip_reset;
      if (wr_stb) begin
        cmd_byte  <= wr_data;
        cmd_index <= reg_index;
      end
    end
  end

  // thirteen causes folded into one level, held until the status is read
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) chip_int <= 1'b0;
    else        chip_int <= |(status1 & mask1) || |(status2 & mask2);
  end

  always_comb begin
    unique case (reg_index)
      vdt_pkg::idx(vdt_pkg::OFF_DATA):     rd_data = rx_byte;
      vdt_pkg::idx(vdt_pkg::OFF_STATUS1):  rd_data = status1;
      vdt_pkg::idx(vdt_pkg::OFF_STATUS2):
        rd_data = {chip_int, status2[6:0]};
      vdt_pkg::idx(vdt_pkg::OFF_POLL):     rd_data = poll_mode;
      vdt_pkg::idx(vdt_pkg::OFF_ADDRESS):  rd_data = addr_status;
      vdt_pkg::idx(vdt_pkg::OFF_AUX):      rd_data = cmd_pass;
      vdt_pkg::idx(vdt_pkg::OFF_OWN_ADDR): rd_data = {1'b0, own_addr0};
      default:                             rd_data = {1'b0, own_addr1};
    endcase
  end

  // during a parallel poll only low-going bits are driven, as open collector
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      ib_o  <= vdt_pkg::BYTE_RESET;
      ib_oe <= vdt_pkg::BYTE_RESET;
    end else if (ppoll_active) begin
      ib_o  <= vdt_pkg::BYTE_RESET;
      ib_oe <= bus_drive ? bus_byte : vdt_pkg::BYTE_RESET;
    end else begin
      ib_o  <= bus_byte;
      ib_oe <= {8{bus_drive}};
    end
  end

endmodule : vdt_port

// *** core/vdt_board.sv ***
// backplane slave and interrupter for a board with two instrument-bus ports
// assumes backplane pins and jumper inputs are asynchronous; port-side logic is on clk_sys
`timescale 1ns/1ps
module vdt_board (
  input  wire logic            clk_sys,
  input  wire logic            rst_n,
  input  wire logic [15:1]     bus_addr,
  input  wire logic [5:0]      bus_am,
  input  wire logic            bus_as_n,
  input  wire logic            bus_ds0_n,
  input  wire logic            bus_ds1_n,
  input  wire logic            bus_write_n,
  input  wire logic            bus_lword_n,
  input  wire logic            bus_iack_n,
  input  wire logic            bus_iackin_n,
  input  wire logic            bus_sysreset_n,
  input  wire logic            bus_sysclk,
  input  wire logic [7:0]      bus_data_i,
  output logic      [7:0]      bus_data_o,
  output logic                 bus_data_oe,
  output logic                 bus_dtack_o,
  output logic                 bus_dtack_oe,
  output logic                 bus_iackout_n,
  output logic      [7:1]      bus_irq_o,
  output logic      [7:1]      bus_irq_oe,
  input  wire logic [10:0]     base_sel,
  input  wire logic            nonpriv_en,
  input  wire logic [1:0][2:0] irq_line_sel,
  input  wire logic [1:0][2:0] prio_code,
  input  wire logic [1:0][7:0] vector_sel,
  input  wire logic [1:0][12:0] port_events,
  input  wire logic [1:0][7:0] port_rx_byte,
  input  wire logic [1:0][7:0] port_addr_status,
  input  wire logic [1:0][7:0] port_cmd_pass,
  input  wire logic [1:0]      port_ppoll,
  input  wire logic [1:0]      port_bus_drive,
  input  wire logic [1:0][7:0] port_bus_byte,
  output logic      [1:0][7:0] port_cmd_byte,
  output logic      [1:0][2:0] port_cmd_index,
  output logic      [1:0]      port_cmd_stb,
  output logic      [1:0]      port_int,
  output logic      [1:0][7:0] port_ib_o,
  output logic      [1:0][7:0] port_ib_oe,
  output logic                 chip_clk,
  output logic                 chip_reset
);
  localparam int SYNC_W = 78;

  logic [SYNC_W-1:0] sync_meta;
  logic [SYNC_W-1:0] sync_hold;
  logic [SYNC_W-1:0] pin_raw;

  assign pin_raw = {bus_addr, bus_am, bus_as_n, bus_ds0_n, bus_ds1_n, bus_write_n,
                    bus_lword_n, bus_iack_n, bus_iackin_n, bus_sysreset_n, bus_sysclk,
                    bus_data_i, base_sel, nonpriv_en, irq_line_sel, prio_code,
                    vector_sel};

  // every backplane pin and jumper passes two flops; only the second is read
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      sync_meta <= '1;
      sync_hold <= '1;
    end else begin
      sync_meta <= pin_raw;
      sync_hold <= sync_meta;
    end
  end

  logic [15:1]     s_addr;
  logic [5:0]      s_am;
  logic            s_as_n;
  logic            s_ds0_n;
  logic            s_ds1_n;
  logic            s_write_n;
  logic            s_lword_n;
  logic            s_iack_n;
  logic            s_iackin_n;
  logic            s_sysreset_n;
  logic            s_sysclk;
  logic [7:0]      s_data;
  logic [10:0]     s_base;
  logic            s_nonpriv;
  logic [1:0][2:0] s_line;
  logic [1:0][2:0] s_prio;
  logic [1:0][7:0] s_vector;

  assign {s_addr, s_am, s_as_n, s_ds0_n, s_ds1_n, s_write_n, s_lword_n, s_iack_n,
          s_iackin_n, s_sysreset_n, s_sysclk, s_data, s_base, s_nonpriv, s_line,
          s_prio, s_vector} = sync_hold;

  // clock and reset
  logic sysclk_prev;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      // matches the all-ones synchroniser reset so no false edge follows reset
      sysclk_prev <= 1'b1;
      chip_clk    <= 1'b0;
    end else begin
      sysclk_prev <= s_sysclk;
      // halves the backplane clock; resolution is limited by the 50 ns sample period
      if (s_sysclk && !sysclk_prev) chip_clk <= !chip_clk;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) chip_reset <= 1'b1;
    else        chip_reset <= !s_sysreset_n;
  end

  // address decode
  logic       am_ok;
  logic       board_hit;
  logic       port_sel;
  logic [2:0] reg_sel;
  logic       strobes_high;

  assign am_ok = (s_am == vdt_pkg::AM_SHORT_SUP) ||
                 (s_nonpriv && s_am == vdt_pkg::AM_SHORT_USER);
  // single odd byte only: data strobe 1 and long word must stay high
  assign board_hit = am_ok && s_addr[15:5] == s_base && s_lword_n && s_ds1_n
                     && s_iack_n;
  assign port_sel     = s_addr[4];
  assign reg_sel      = s_addr[3:1];
  assign strobes_high = s_ds0_n && s_ds1_n;

  // interrupter request state
  logic [1:0] irq_drive;
  logic [1:0] irq_acked;
  logic [1:0] ack_match;
  logic [1:0] chip_int;
  logic       ack_port;
  logic       ack_is_irq;

  genvar gp;
  generate
    for (gp = 0; gp < 2; gp = gp + 1) begin : g_match
      assign ack_match[gp] = irq_drive[gp] && s_prio[gp] == s_addr[3:1];
    end
  endgenerate

  // timing state machine
  vdt_pkg::vdt_state_t state;
  logic [1:0]          wr_stb;
  logic [1:0]          rd_stb;
  logic [1:0][7:0]     rd_data;
  logic [7:0]          wr_byte;
  logic [2:0]          reg_latch;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      state         <= vdt_pkg::ST_IDLE;
      bus_data_o    <= vdt_pkg::BYTE_RESET;
      bus_data_oe   <= 1'b0;
      bus_dtack_oe  <= 1'b0;
      bus_iackout_n <= 1'b1;
      wr_stb        <= 2'b00;
      rd_stb        <= 2'b00;
      wr_byte       <= vdt_pkg::BYTE_RESET;
      reg_latch     <= vdt_pkg::INDEX_RESET;
      ack_port      <= 1'b0;
      ack_is_irq    <= 1'b0;
    end else begin
      wr_stb <= 2'b00;
      rd_stb <= 2'b00;
      unique case (state)
        vdt_pkg::ST_IDLE: begin
          ack_is_irq <= 1'b0;
          // without a data strobe the cycle is address-only and nothing happens
          if (!s_as_n && !s_ds0_n) begin
            if (!s_iack_n) begin
              if (!s_iackin_n) begin
                if (ack_match[0] || ack_match[1]) begin
                  ack_port     <= !ack_match[0];
                  ack_is_irq   <= 1'b1;
                  bus_data_o   <= ack_match[0] ? s_vector[0] : s_vector[1];
                  bus_data_oe  <= 1'b1;
                  bus_dtack_oe <= 1'b1;
                  state        <= vdt_pkg::ST_ACK;
                end else begin
                  bus_iackout_n <= 1'b0;
                  state         <= vdt_pkg::ST_PASS;
                end
              end
            end else if (board_hit) begin
              reg_latch <= reg_sel;
              if (!s_write_n) begin
                wr_byte          <= s_data;
                wr_stb[port_sel] <= 1'b1;
              end else begin
                // read data is taken before the read side effect lands
                rd_stb[port_sel] <= 1'b1;
                bus_data_o       <= rd_data[port_sel];
                bus_data_oe      <= 1'b1;
              end
              bus_dtack_oe <= 1'b1;
              state        <= vdt_pkg::ST_ACK;
            end else begin
              state <= vdt_pkg::ST_RELEASE;
            end
          end
        end
        vdt_pkg::ST_ACK: begin
          if (strobes_high) begin
            bus_data_oe  <= 1'b0;
            bus_dtack_oe <= 1'b0;
            state        <= vdt_pkg::ST_IDLE;
          end
        end
        vdt_pkg::ST_PASS: begin
          if (s_ds0_n) begin
            bus_iackout_n <= 1'b1;
            state         <= vdt_pkg::ST_IDLE;
          end
        end
        default: begin
          if (strobes_high) state <= vdt_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // release on acknowledge; re-arm only after the chip interrupt has dropped
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      irq_acked <= 2'b00;
      irq_drive <= 2'b00;
    end else if (chip_reset) begin
      irq_acked <= 2'b00;
      irq_drive <= 2'b00;
    end else begin
      for (int p = 0; p < 2; p++) begin
        if (state == vdt_pkg::ST_ACK && ack_is_irq && ack_port == p[0] && s_ds0_n)
          irq_acked[p] <= 1'b1;
        else if (!chip_int[p])
          irq_acked[p] <= 1'b0;
        irq_drive[p] <= chip_int[p] && !irq_acked[p] &&
                        !(state == vdt_pkg::ST_ACK && ack_is_irq &&
                          ack_port == p[0] && s_ds0_n);
      end
    end
  end

  genvar gl;
  generate
    for (gl = 1; gl < 8; gl = gl + 1) begin : g_irq
      always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) bus_irq_oe[gl] <= 1'b0;
        else        bus_irq_oe[gl] <= (irq_drive[0] && s_line[0] == 3'(gl)) ||
                                      (irq_drive[1] && s_line[1] == 3'(gl));
      end
    end
  endgenerate

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      bus_irq_o   <= 7'h00;
      bus_dtack_o <= 1'b0;
      port_int    <= 2'b00;
    end else begin
      bus_irq_o   <= 7'h00;
      bus_dtack_o <= 1'b0;
      port_int    <= chip_int;
    end
  end

  // two independent ports
  generate
    for (gp = 0; gp < 2; gp = gp + 1) begin : g_port
      vdt_port u_port (
        .clk_sys      (clk_sys),
        .rst_n        (rst_n),
        .chip_reset   (chip_reset),
        .reg_index    (wr_stb[gp] || rd_stb[gp] ? reg_latch : reg_sel),
        .wr_stb       (wr_stb[gp]),
        .rd_stb       (rd_stb[gp]),
        .wr_data      (wr_byte),
        .events       (port_events[gp]),
        .rx_byte      (port_rx_byte[gp]),
        .addr_status  (port_addr_status[gp]),
        .cmd_pass     (port_cmd_pass[gp]),
        .ppoll_active (port_ppoll[gp]),
        .bus_drive    (port_bus_drive[gp]),
        .bus_byte     (port_bus_byte[gp]),
        .rd_data      (rd_data[gp]),
        .chip_int     (chip_int[gp]),
        .cmd_byte     (port_cmd_byte[gp]),
        .cmd_index    (port_cmd_index[gp]),
        .cmd_stb      (port_cmd_stb[gp]),
        .ib_o         (port_ib_o[gp]),
        .ib_oe        (port_ib_oe[gp])
      );
    end
  endgenerate

endmodule : vdt_board

// *** verif/vdt_props.sv ***
// assertions on the board's backplane slave and interrupter pins
// assumes it is bound to the board's top module; everything runs on clk_sys
`timescale 1ns/1ps
module vdt_props (
  input wire logic            clk_sys,
  input wire logic            rst_n,
  input wire logic [15:1]     bus_addr,
  input wire logic [5:0]      bus_am,
  input wire logic            bus_ds0_n,
  input wire logic            bus_ds1_n,
  input wire logic            bus_write_n,
  input wire logic            bus_iack_n,
  input wire logic            bus_sysreset_n,
  input wire logic [10:0]     base_sel,
  input wire logic            nonpriv_en,
  input wire logic [1:0][2:0] irq_line_sel,
  input wire logic [1:0][2:0] prio_code,
  input wire logic [1:0][7:0] vector_sel,
  input wire logic [7:0]      bus_data_o,
  input wire logic            bus_data_oe,
  input wire logic            bus_dtack_oe,
  input wire logic [7:1]      bus_irq_oe,
  input wire logic [1:0]      port_int,
  input wire logic            chip_reset
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_n);

  sequence s_idle;
    (bus_ds0_n && bus_ds1_n) [*5];
  endsequence
  sequence s_ds_up;
    $rose(bus_ds0_n) && bus_ds1_n;
  endsequence
  // six samples so the synchronisers have seen the stable pins
  sequence s_bad_am;
    (!bus_ds0_n && bus_iack_n && bus_am != vdt_pkg::AM_SHORT_SUP
     && !(nonpriv_en && bus_am == vdt_pkg::AM_SHORT_USER)) [*6];
  endsequence
  sequence s_bad_base;
    (!bus_ds0_n && bus_iack_n && bus_addr[15:5] != base_sel) [*6];
  endsequence

  property p_irq_drive;
    $rose(port_int[0]) && !chip_reset |-> ##[0:3] bus_irq_oe[irq_line_sel[0]];
  endproperty
  a_irq_drive: assert property (p_irq_drive) else $error("line not driven");
  property p_write_quiet;
    bus_data_oe |-> bus_write_n;
  endproperty
  a_write_quiet: assert property (p_write_quiet) else $error("drive in write");
  property p_dtack_off;
    s_ds_up |-> ##[1:5] !bus_dtack_oe;
  endproperty
  a_dtack_off: assert property (p_dtack_off) else $error("ack held");
  property p_data_off;
    s_ds_up |-> ##[1:5] !bus_data_oe;
  endproperty
  a_data_off: assert property (p_data_off) else $error("data held");
  property p_addr_only;
    s_idle |-> !bus_dtack_oe && !bus_data_oe;
  endproperty
  a_addr_only: assert property (p_addr_only) else $error("answer w/o strobe");
  property p_am;
    s_bad_am |-> !bus_dtack_oe;
  endproperty
  a_am: assert property (p_am) else $error("bad modifier answered");
  property p_base;
    s_bad_base |-> !bus_dtack_oe;
  endproperty
  a_base: assert property (p_base) else $error("foreign address answered");
  property p_vector;
    bus_data_oe && !bus_iack_n |->
      (bus_data_o == vector_sel[0] && bus_addr[3:1] == prio_code[0])
      || (bus_data_o == vector_sel[1] && bus_addr[3:1] == prio_code[1]);
  endproperty
  a_vector: assert property (p_vector) else $error("wrong vector");
  property p_sysreset;
    !bus_sysreset_n [*6] |-> chip_reset && bus_irq_oe == 7'h00;
  endproperty
  a_sysreset: assert property (p_sysreset) else $error("reset not applied");
endmodule : vdt_props

bind vdt_board vdt_props u_props (.*);

// *** verif/vdt_master.sv ***
// backplane master and interrupt handler model facing the board's slave pins
// assumes registered answers on clk_sys; the shared data wire is resolved here
`timescale 1ns/1ps
module vdt_master (
  input  wire logic        clk_sys,
  input  wire logic        bus_dtack_oe,
  input  wire logic        bus_data_oe,
  input  wire logic [7:0]  bus_data_o,
  input  wire logic        bus_iackout_n,
  output logic      [15:1] bus_addr,
  output logic      [5:0]  bus_am,
  output logic             bus_as_n,
  output logic             bus_ds0_n,
  output logic             bus_ds1_n,
  output logic             bus_write_n,
  output logic             bus_lword_n,
  output logic             bus_iack_n,
  output logic             bus_iackin_n,
  output logic      [7:0]  bus_data_i
);
  logic       drv;
  logic [7:0] wd;
  logic [7:0] last;
  // a released bus shows the inverse of its last value, never a held copy
  assign bus_data_i = drv ? wd : (bus_data_oe ? bus_data_o : ~last);
  initial begin
    {bus_as_n, bus_ds0_n, bus_ds1_n, bus_write_n} = 4'hF;
    {bus_lword_n, bus_iack_n, bus_iackin_n} = 3'h7;
    bus_addr = '0;
    bus_am = vdt_pkg::AM_SHORT_SUP;
    drv = '0;
    wd = '0;
    last = '0;
  end
  task automatic cyc(input logic ia, input logic w, input logic [15:1] a,
                     input logic [5:0] am, input logic [7:0] d, input int lag,
                     output logic [7:0] rd, output logic ack, output logic pass);
    ack = '0;
    pass = '0;
    rd = '0;
    @(posedge clk_sys);
    #1;
    bus_addr = a;
    bus_am = am;
    bus_write_n = ~w;
    {bus_iack_n, bus_iackin_n} = {2{~ia}};
    wd = d;
    drv = w;
    bus_as_n = '0;
    bus_ds0_n = '0;
    for (int i = 0; i < 12 && !ack; i++) begin
      @(posedge clk_sys);
      ack = bus_dtack_oe;
      rd = bus_data_o;
      pass = pass | ~bus_iackout_n;
    end
    repeat (lag) @(posedge clk_sys);
    #1;
    last = bus_data_i;
    {bus_as_n, bus_ds0_n, bus_iack_n, bus_iackin_n} = 4'hF;
    drv = '0;
    // strobes stay high long enough for the synchronised slave to see them
    for (int i = 0; i < 8 && (i < 3 || bus_dtack_oe); i++) @(posedge clk_sys);
  endtask : cyc
  task automatic ado(input logic [15:1] a);
    @(posedge clk_sys);
    #1;
    bus_addr = a;
    bus_as_n = '0;
    repeat (6) @(posedge clk_sys);
    #1;
    bus_as_n = '1;
  endtask : ado
endmodule : vdt_master

// *** verif/vme_dual_talker_port_slave_tb.sv ***
// self-checking bench: board slave driven by the master model
// assumes the checker is bound to the board; inputs change 1 ns after clk_sys rises
`timescale 1ns/1ps
module vme_dual_talker_port_slave_tb;
  `define check_eq(act, exp) begin \
    samples_checked++; \
    if ((act) !== (exp)) begin \
      num_errors++; \
      $display("ERROR t=%0t got %h want %h", $time, (act), (exp)); \
    end \
  end
  typedef struct packed {logic w; logic [4:0] off; logic [7:0] d;} vdt_row_t;
  localparam logic [10:0] BASE = 11'h080;
  logic clk_sys, rst_n, bus_sysreset_n, bus_sysclk, nonpriv_en;
  logic [15:1] bus_addr;
  logic [5:0] bus_am;
  logic bus_as_n, bus_ds0_n, bus_ds1_n, bus_write_n, bus_lword_n, bus_iack_n, bus_iackin_n;
  logic [7:0] bus_data_i, bus_data_o, rd;
  logic bus_data_oe, bus_dtack_o, bus_dtack_oe, bus_iackout_n, chip_clk, chip_reset, ack, pass;
  logic [7:1] bus_irq_o, bus_irq_oe;
  logic [10:0] base_sel;
  logic [1:0][2:0] irq_line_sel, prio_code, port_cmd_index;
  logic [1:0][7:0] vector_sel, port_rx_byte, port_addr_status, port_cmd_pass, port_bus_byte;
  logic [1:0][7:0] port_cmd_byte, port_ib_o, port_ib_oe;
  logic [1:0][12:0] port_events;
  logic [1:0] port_ppoll, port_bus_drive, port_cmd_stb, port_int;
  int num_errors = 0;
  int samples_checked = 0;
  int tog = 0;
  int t0;
  int stb_n = 0;
  vdt_row_t rows [12] = '{'{1'h1, 5'h0D, 8'h85}, '{1'h0, 5'h0F, 8'h05}, '{1'h0, 5'h0D, 8'h00},
    '{1'h1, 5'h1D, 8'h03}, '{1'h0, 5'h1D, 8'h03}, '{1'h1, 5'h07, 8'h41},
    '{1'h0, 5'h07, 8'h41}, '{1'h0, 5'h01, 8'hA5}, '{1'h1, 5'h11, 8'hE7},
    '{1'h0, 5'h11, 8'h5A}, '{1'h0, 5'h09, 8'h3C}, '{1'h0, 5'h1B, 8'hC3}};

  vdt_board dut (.*);
  vdt_master u_m (.*);
  always @(chip_clk) tog++;
  always @(posedge clk_sys) stb_n += port_cmd_stb[0] + port_cmd_stb[1];
  initial begin
    clk_sys = '0;
    forever #25 clk_sys = ~clk_sys;
  end
  initial begin
    bus_sysclk = '0;
    forever #31 bus_sysclk = ~bus_sysclk;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask : tick
  task automatic acc(input logic w, input logic [4:0] off, input logic [7:0] d, input int lag);
    u_m.cyc('0, w, {BASE, off[4:1]}, vdt_pkg::AM_SHORT_SUP, d, lag, rd, ack, pass);
  endtask : acc
  task automatic iak(input logic [2:0] lvl);
    u_m.cyc('1, '0, {12'h000, lvl}, vdt_pkg::AM_SHORT_SUP, 8'h00, 0, rd, ack, pass);
  endtask : iak
  task automatic ev(input int p, input int b);
    tick(1);
    port_events[p][b] = '1;
    tick(1);
    port_events[p][b] = '0;
  endtask : ev
  task automatic wrap_up();
    $display("comparisons %0d errors %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : wrap_up
  initial begin
    repeat (20000) @(posedge clk_sys);
    num_errors++;
    wrap_up();
  end
  initial begin
    {rst_n, bus_sysreset_n, nonpriv_en} = 3'h2;
    base_sel = BASE;
    irq_line_sel = {3'h4, 3'h2};
    prio_code = {3'h4, 3'h2};
    vector_sel = {8'h77, 8'h4E};
    port_events = '0;
    port_rx_byte = {8'h5A, 8'hA5};
    port_addr_status = {8'h00, 8'h3C};
    port_cmd_pass = {8'hC3, 8'h00};
    {port_ppoll, port_bus_drive} = 4'h1;
    port_bus_byte = {8'h69, 8'h96};
    tick(5);
    rst_n = '1;
    tick(8);
    t0 = tog;
    foreach (rows[i]) begin
      acc(rows[i].w, rows[i].off, rows[i].d, i % 3);
      `check_eq(ack, 1'h1)
      if (rows[i].w) begin
        `check_eq(port_cmd_byte[rows[i].off[4]], rows[i].d)
        `check_eq(port_cmd_index[rows[i].off[4]], rows[i].off[3:1])
      end else begin
        `check_eq(rd, rows[i].d)
      end
    end
    `check_eq(stb_n, 4)
    ev(0, vdt_pkg::EV_TRIGGER);
    tick(4);
    `check_eq(port_int[0], 1'h0)
    acc('0, 5'h03, 8'h00, 0);
    `check_eq(rd, 8'h20)
    acc('1, 5'h03, 8'h01, 0);
    ev(0, vdt_pkg::EV_DATA_IN);
    tick(4);
    `check_eq({port_int, bus_irq_oe}, 9'h082)
    iak(3'h2);
    `check_eq(rd, 8'h4E)
    tick(3);
    `check_eq({port_int[0], bus_irq_oe}, 8'h80)
    acc('0, 5'h03, 8'h00, 1);
    `check_eq(rd, 8'h01)
    tick(3);
    `check_eq(port_int[0], 1'h0)
    acc('1, 5'h15, 8'h01, 0);
    ev(1, vdt_pkg::EV_ADDR_CHG);
    tick(4);
    `check_eq({port_int, bus_irq_oe}, 9'h108)
    iak(3'h2);
    `check_eq({ack, pass}, 2'h1)
    iak(3'h4);
    `check_eq(rd, 8'h77)
    acc('0, 5'h15, 8'h00, 0);
    `check_eq(rd[3:0], 4'h1)
    for (int k = 0; k < 4; k++) begin
      tick(1);
      nonpriv_en = (k == 2);
      tick(3);
      u_m.cyc('0, '0, {BASE + 11'(k == 3), 4'h0}, k == 0 ? 6'h39 : (k == 3 ? 6'h2D : 6'h29),
              8'h00, 0, rd, ack, pass);
      `check_eq(ack, 1'(k == 2))
    end
    u_m.ado({BASE, 4'h0});
    `check_eq(bus_dtack_oe, 1'h0)
    acc('0, 5'h01, 8'h00, 0);
    `check_eq(rd, 8'hA5)
    `check_eq(port_ib_oe[0], 8'hFF)
    port_ppoll = 2'h1;
    tick(2);
    `check_eq({port_ib_o[0], port_ib_oe[0]}, 16'h0096)
    acc('1, 5'h03, 8'h01, 0);
    ev(0, 0);
    tick(3);
    bus_sysreset_n = '0;
    tick(6);
    `check_eq({chip_reset, bus_irq_oe}, 8'h80)
    bus_sysreset_n = '1;
    tick(8);
    `check_eq(port_int, 2'h0)
    acc('0, 5'h07, 8'h00, 0);
    `check_eq(rd, 8'h00)
    `check_eq(tog > t0 + 2, 1'h1)
    `check_eq({bus_dtack_o, bus_irq_o}, 8'h00)
    wrap_up();
  end
endmodule : vme_dual_talker_port_slave_tb
